// File: include/peer_isolation_consts.svh
// Register indices, byte addresses, field positions and reset values of the
// peer isolation capability block.
// Assumes a 12-bit APB byte address and 32-bit data, one register per word.
`ifndef PEER_ISOLATION_CONSTS_SVH
`define PEER_ISOLATION_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register indices and byte addresses (byte address is four times the index)
// ----------------------------------------------------------------------------
`define IDX_HEADER 12'h320
`define IDX_CAPABILITY 12'h324
`define IDX_CONTROL 12'h326
`define IDX_EGRESS_MASK 12'h328
`define IDX_SETUP 12'h32C
`define IDX_STATUS 12'h32D
`define ADDR_HEADER 12'(`IDX_HEADER << 2)
`define ADDR_CAPABILITY 12'(`IDX_CAPABILITY << 2)
`define ADDR_CONTROL 12'(`IDX_CONTROL << 2)
`define ADDR_EGRESS_MASK 12'(`IDX_EGRESS_MASK << 2)
`define ADDR_SETUP 12'(`IDX_SETUP << 2)
`define ADDR_STATUS 12'(`IDX_STATUS << 2)

// ----------------------------------------------------------------------------
// Field widths, positions and fixed values
// ----------------------------------------------------------------------------
`define STRUCT_ID 16'h000D
`define STRUCT_REV 4'h1
`define NUM_FEATURES 7
`define FEAT_EGRESS_BIT 5
`define MASK_W 16
`define SETUP_UNLOCK_BIT 0
`define STATUS_UP_BIT 0
`define STATUS_MERGED_BIT 1
`define STATUS_UNLOCK_BIT 2
`define STATUS_PORT_LSB 4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define NEXT_LINK_RST 12'h000
`define FEATURES_RST 7'h7F
`define EGRESS_SIZE_RST 8'h10
`define CONTROL_RST 7'h00
`define EGRESS_MASK_RST 16'h0000
`define SETUP_RST 1'h0

`endif

// File: include/peer_isolation_pkg.sv
// Types shared by the peer isolation capability block.
// Assumes nothing of its surroundings.
package peer_isolation_pkg;

    // ------------------------------------------------------------------------
    // Register selection and bus answer phase
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_HEADER,
        SEL_CAPABILITY,
        SEL_CONTROL,
        SEL_EGRESS_MASK,
        SEL_SETUP,
        SEL_STATUS
    } reg_sel_t;

    typedef enum {
        PH_WAIT,
        PH_ANSWER
    } apb_phase_t;

endpackage : peer_isolation_pkg

// File: hw/maskable_field.sv
// One register field whose bits are written only where a write mask allows.
// Assumes the caller forms the mask from role, lock and byte strobes.
`timescale 1ns/1ps

module maskable_field #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Write request
    input wire logic wr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [WIDTH-1:0] wmask,
    // Stored value
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] q_r;
    logic [WIDTH-1:0] q_nxt;

    // Bits outside the mask keep their stored value.
    always_comb begin
        q_nxt = q_r;
        if (wr) begin
            q_nxt = (q_r & ~wmask) | (wdata & wmask);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_r <= RESET_VALUE;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign q = q_r;

endmodule : maskable_field

// File: hw/peer_isolation_capability_regs.sv
// Peer isolation capability registers of one switch port, reached over APB.
// Assumes role, port number and merge state come from logic on pclk, and that
// the forwarding datapath consumes the enables and the blocking decision.
//
// Behaviour
// - Header bits 15:0 read the fixed structure identifier 0xD.
// - Header bits 19:16 read the fixed structure revision 0x1.
// - Header bits 31:20 hold the next link, writable only while unlocked.
// - Feature bits 6:0 read zero upstream; downstream lock-writable, default one.
// - Egress size bits 15:8 read zero upstream; downstream lock-writable, default 0x10.
// - Egress size has no meaning while egress support is clear.
// - Control bits 6:0 reset zero, upstream read-only, downstream writable; 15:7 zero.
// - Downstream control bits stay writable even when support bits are cleared.
// - Egress mask bits 15:0 reset zero; bit i stands for switch port i.
// - A set mask bit blocks peer requests aimed at that port.
// - The mask acts only while the egress control enable is set.
// - The mask bit of the port's own number reads zero, read-only.
// - In merged mode mask bits N and N+1 of even port N read zero.
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`include "peer_isolation_consts.svh"

module peer_isolation_capability_regs (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Port configuration from the switch core
    input wire logic port_is_upstream,
    input wire logic [3:0] port_number,
    input wire logic port_merged,
    // Peer request lookup from the forwarding path
    input wire logic req_valid,
    input wire logic [3:0] req_target,
    // Controls to the forwarding path
    output logic [6:0] feature_enable,
    output logic [15:0] egress_block_mask,
    output logic req_blocked
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    peer_isolation_pkg::apb_phase_t phase_r;
    peer_isolation_pkg::apb_phase_t phase_nxt;
    peer_isolation_pkg::reg_sel_t sel;
    logic pready_r;
    logic pready_nxt;
    logic pslverr_r;
    logic pslverr_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic [31:0] lane_mask;
    logic wr_commit;
    logic unlock;
    logic [15:0] ro_mask;
    logic [15:0] mask_view;
    logic [11:0] next_link_q;
    logic [6:0] features_q;
    logic [7:0] egress_size_q;
    logic [6:0] control_q;
    logic [15:0] egress_mask_q;
    logic [0:0] setup_q;
    logic [11:0] link_wmask;
    logic [6:0] feat_wmask;
    logic [7:0] size_wmask;
    logic [6:0] ctl_wmask;
    logic [15:0] mask_wmask;
    logic [0:0] setup_wmask;
    logic [31:0] read_word;
    logic [6:0] feature_enable_r;
    logic [6:0] feature_enable_nxt;
    logic [15:0] egress_block_mask_r;
    logic [15:0] egress_block_mask_nxt;
    logic req_blocked_r;
    logic req_blocked_nxt;

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    always_comb begin
        case (paddr)
            `ADDR_HEADER: sel = peer_isolation_pkg::SEL_HEADER;
            `ADDR_CAPABILITY: sel = peer_isolation_pkg::SEL_CAPABILITY;
            `ADDR_CONTROL: sel = peer_isolation_pkg::SEL_CONTROL;
            `ADDR_EGRESS_MASK: sel = peer_isolation_pkg::SEL_EGRESS_MASK;
            `ADDR_SETUP: sel = peer_isolation_pkg::SEL_SETUP;
            `ADDR_STATUS: sel = peer_isolation_pkg::SEL_STATUS;
            default: sel = peer_isolation_pkg::SEL_NONE;
        endcase
    end

    // ------------------------------------------------------------------------
    // APB answer sequencing
    // ------------------------------------------------------------------------
    // The answer is prepared in the first access cycle and signalled in the
    // second, so prdata and pready both come straight from flip-flops.
    always_comb begin
        phase_nxt = phase_r;
        pready_nxt = 1'b0;
        pslverr_nxt = 1'b0;
        prdata_nxt = prdata_r;
        case (phase_r)
            peer_isolation_pkg::PH_WAIT: begin
                if (psel && penable) begin
                    phase_nxt = peer_isolation_pkg::PH_ANSWER;
                    pready_nxt = 1'b1;
                    pslverr_nxt = (sel == peer_isolation_pkg::SEL_NONE);
                    prdata_nxt = pwrite ? 32'h0000_0000 : read_word;
                end
            end
            peer_isolation_pkg::PH_ANSWER: begin
                phase_nxt = peer_isolation_pkg::PH_WAIT;
            end
            default: begin
                phase_nxt = peer_isolation_pkg::PH_WAIT;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_r <= peer_isolation_pkg::PH_WAIT;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            phase_r <= phase_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    // A write lands at the edge where the master sees pready high.
    assign wr_commit = psel && penable && pwrite && pready_r && !pslverr_r;
    assign lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    // ------------------------------------------------------------------------
    // Write masks by role, lock and merge state
    // ------------------------------------------------------------------------
    assign unlock = setup_q[`SETUP_UNLOCK_BIT];

    always_comb begin
        ro_mask = 16'h0001 << port_number;
        if (port_merged && !port_number[0]) begin
            ro_mask = ro_mask | (16'h0001 << (port_number + 4'h1));
        end
    end

    always_comb begin
        link_wmask = unlock ? lane_mask[31:20] : 12'h000;
        feat_wmask = 7'h00;
        size_wmask = 8'h00;
        ctl_wmask = 7'h00;
        if (!port_is_upstream && unlock) begin
            feat_wmask = lane_mask[6:0];
            size_wmask = lane_mask[15:8];
        end
        if (!port_is_upstream) begin
            ctl_wmask = lane_mask[6:0];
        end
        mask_wmask = lane_mask[15:0] & ~ro_mask;
        setup_wmask = lane_mask[0:0];
    end

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    maskable_field #(.WIDTH(12), .RESET_VALUE(`NEXT_LINK_RST)) u_next_link (
        .pclk(pclk),
        .presetn(presetn),
        .wr(wr_commit && sel == peer_isolation_pkg::SEL_HEADER),
        .wdata(pwdata[31:20]),
        .wmask(link_wmask),
        .q(next_link_q)
    );

    maskable_field #(.WIDTH(7), .RESET_VALUE(`FEATURES_RST)) u_features (
        .pclk(pclk),
        .presetn(presetn),
        .wr(wr_commit && sel == peer_isolation_pkg::SEL_CAPABILITY),
        .wdata(pwdata[6:0]),
        .wmask(feat_wmask),
        .q(features_q)
    );

    // The size is stored as written whatever the egress support bit says.
    maskable_field #(.WIDTH(8), .RESET_VALUE(`EGRESS_SIZE_RST)) u_egress_size (
        .pclk(pclk),
        .presetn(presetn),
        .wr(wr_commit && sel == peer_isolation_pkg::SEL_CAPABILITY),
        .wdata(pwdata[15:8]),
        .wmask(size_wmask),
        .q(egress_size_q)
    );

    maskable_field #(.WIDTH(7), .RESET_VALUE(`CONTROL_RST)) u_control (
        .pclk(pclk),
        .presetn(presetn),
        .wr(wr_commit && sel == peer_isolation_pkg::SEL_CONTROL),
        .wdata(pwdata[6:0]),
        .wmask(ctl_wmask),
        .q(control_q)
    );

    maskable_field #(.WIDTH(16), .RESET_VALUE(`EGRESS_MASK_RST)) u_egress_mask (
        .pclk(pclk),
        .presetn(presetn),
        .wr(wr_commit && sel == peer_isolation_pkg::SEL_EGRESS_MASK),
        .wdata(pwdata[15:0]),
        .wmask(mask_wmask),
        .q(egress_mask_q)
    );

    maskable_field #(.WIDTH(1), .RESET_VALUE(`SETUP_RST)) u_setup (
        .pclk(pclk),
        .presetn(presetn),
        .wr(wr_commit && sel == peer_isolation_pkg::SEL_SETUP),
        .wdata(pwdata[0:0]),
        .wmask(setup_wmask),
        .q(setup_q)
    );

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    // Bits that are fixed at zero read zero even if an old value is stored.
    assign mask_view = egress_mask_q & ~ro_mask;

    always_comb begin
        read_word = 32'h0000_0000;
        case (sel)
            peer_isolation_pkg::SEL_HEADER: begin
                read_word = {next_link_q, `STRUCT_REV, `STRUCT_ID};
            end
            peer_isolation_pkg::SEL_CAPABILITY: begin
                if (!port_is_upstream) begin
                    read_word[15:8] = egress_size_q;
                    read_word[6:0] = features_q;
                end
            end
            peer_isolation_pkg::SEL_CONTROL: begin
                if (!port_is_upstream) begin
                    read_word[6:0] = control_q;
                end
            end
            peer_isolation_pkg::SEL_EGRESS_MASK: begin
                read_word[15:0] = mask_view;
            end
            peer_isolation_pkg::SEL_SETUP: begin
                read_word[`SETUP_UNLOCK_BIT] = unlock;
            end
            peer_isolation_pkg::SEL_STATUS: begin
                read_word[`STATUS_UP_BIT] = port_is_upstream;
                read_word[`STATUS_MERGED_BIT] = port_merged;
                read_word[`STATUS_UNLOCK_BIT] = unlock;
                read_word[`STATUS_PORT_LSB +: 4] = port_number;
            end
            default: begin
                read_word = 32'h0000_0000;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Controls to the forwarding path
    // ------------------------------------------------------------------------
    always_comb begin
        feature_enable_nxt = port_is_upstream ? 7'h00 : control_q;
        egress_block_mask_nxt = 16'h0000;
        if (feature_enable_nxt[`FEAT_EGRESS_BIT]) begin
            egress_block_mask_nxt = mask_view;
        end
        req_blocked_nxt = req_valid && egress_block_mask_r[req_target];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            feature_enable_r <= 7'h00;
            egress_block_mask_r <= 16'h0000;
            req_blocked_r <= 1'b0;
        end else begin
            feature_enable_r <= feature_enable_nxt;
            egress_block_mask_r <= egress_block_mask_nxt;
            req_blocked_r <= req_blocked_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign feature_enable = feature_enable_r;
    assign egress_block_mask = egress_block_mask_r;
    assign req_blocked = req_blocked_r;

endmodule : peer_isolation_capability_regs

// File: bench/peer_isolation_asserts.sv
// Concurrent checks on the ports of the peer isolation register block.
// Assumes role, port number and merge state stay steady across each access.
`timescale 1ns/1ps
`include "peer_isolation_consts.svh"

module peer_isolation_asserts (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB answer
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Port state
    input wire logic port_is_upstream,
    input wire logic [3:0] port_number,
    input wire logic port_merged,
    // Lookup and forwarding controls
    input wire logic req_valid,
    input wire logic [3:0] req_target,
    input wire logic [6:0] feature_enable,
    input wire logic [15:0] egress_block_mask,
    input wire logic req_blocked
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ----------
    // Checks
    // ----------
    // A good read answer is on the bus in this cycle.
    wire logic rd = pready && !pwrite && !pslverr;

    chk_header_fixed:
        assert property (rd && paddr == `ADDR_HEADER |-> prdata[19:0] == 20'h1000D)
        else $error("Header identifier or revision wrong.");
    chk_cap_upstream:
        assert property (rd && paddr == `ADDR_CAPABILITY && port_is_upstream |-> prdata == 32'h0)
        else $error("Upstream capability not zero.");
    chk_control_upper:
        assert property (rd && paddr == `ADDR_CONTROL |-> prdata[31:7] == 25'h0)
        else $error("Control upper bits not zero.");
    chk_upstream_quiet:
        assert property (port_is_upstream [*2] |-> feature_enable == 7'h00)
        else $error("Upstream port drives feature enables.");
    chk_mask_own:
        assert property (rd && paddr == `ADDR_EGRESS_MASK |-> prdata[port_number] == 1'b0)
        else $error("Own mask bit reads one.");
    chk_mask_merged:
        assert property (rd && paddr == `ADDR_EGRESS_MASK && port_merged && !port_number[0]
                         |-> prdata[port_number + 4'h1] == 1'b0)
        else $error("Merged partner mask bit reads one.");
    chk_egress_gate:
        assert property (egress_block_mask != 16'h0 |-> feature_enable[5])
        else $error("Mask active without egress enable.");
    chk_block_set:
        assert property (req_valid && egress_block_mask[req_target] |=> req_blocked)
        else $error("Masked target not blocked.");
    chk_block_clear:
        assert property (!req_valid || !egress_block_mask[req_target] |=> !req_blocked)
        else $error("Unmasked target blocked.");
endmodule : peer_isolation_asserts

bind peer_isolation_capability_regs peer_isolation_asserts chk_u (
    .pclk(pclk), .presetn(presetn), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_is_upstream(port_is_upstream),
    .port_number(port_number), .port_merged(port_merged), .req_valid(req_valid),
    .req_target(req_target), .feature_enable(feature_enable),
    .egress_block_mask(egress_block_mask), .req_blocked(req_blocked)
);

// File: bench/tb_peer_isolation_capability_regs.sv
// Self-checking bench of the peer isolation register block over APB.
// Assumes every access is answered by a one-cycle pready pulse.
`timescale 1ns/1ps
`include "peer_isolation_consts.svh"

`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin failures++; \
    $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp); end end

module tb_peer_isolation_capability_regs;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [3:0] pstrb = 4'h0, port_number = 4'h3, req_target = 4'h0;
    logic port_is_upstream = 1'b0, port_merged = 1'b0, req_valid = 1'b0, rv_d = 1'b0;
    logic pready, pslverr, req_blocked;
    logic [23:0] b;
    logic [6:0] feature_enable;
    logic [15:0] egress_block_mask, m;
    logic [32:0] e;
    logic [32:0] ans_q[$];
    logic [23:0] blk_q[$];
    int failures = 0, n_tests = 0;

    peer_isolation_capability_regs dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_is_upstream(port_is_upstream), .port_number(port_number),
        .port_merged(port_merged), .req_valid(req_valid), .req_target(req_target),
        .feature_enable(feature_enable), .egress_block_mask(egress_block_mask),
        .req_blocked(req_blocked)
    );

    always #2.5 pclk = ~pclk;

    // ----------
    // Monitor
    // ----------
    // Each answer and each lookup result takes the oldest note of its queue.
    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            e = ans_q.pop_front();
            `CHK({pslverr, prdata}, e)
        end
        if (rv_d === 1'b1) begin
            b = blk_q.pop_front();
            `CHK({feature_enable, egress_block_mask, req_blocked}, b)
        end
        rv_d = req_valid;
    end

    // ----------
    // Tasks
    // ----------
    // The request stays up after pready so a following access can start at once.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [32:0] x);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        ans_q.push_back(x);
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
        xfer(1'b1, a, d, s, 33'h0);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        xfer(1'b0, a, 32'h0, 4'h0, {1'b0, x});
    endtask : rd

    task automatic idle();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : idle

    task automatic look(input logic [3:0] t, input logic [23:0] x);
        req_valid <= 1'b1;
        req_target <= t;
        blk_q.push_back(x);
        @(posedge pclk);
    endtask : look

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict

    // ----------
    // Tests
    // ----------
    initial begin
        #100000;
        failures++;
        give_verdict();
    end

    initial begin
        void'($urandom(76170));
        r = $urandom();
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(`ADDR_HEADER, 32'h0001000D);
        rd(`ADDR_CAPABILITY, 32'h0000107F);
        rd(`ADDR_CONTROL, 32'h0);
        rd(`ADDR_EGRESS_MASK, 32'h0);
        wr(`ADDR_HEADER, 32'hFFFFFFFF);
        rd(`ADDR_HEADER, 32'h0001000D);
        wr(`ADDR_SETUP, 32'h1);
        rd(`ADDR_SETUP, 32'h1);
        rd(`ADDR_STATUS, 32'h34);
        wr(`ADDR_HEADER, r);
        rd(`ADDR_HEADER, {r[31:20], 20'h1000D});
        wr(`ADDR_CAPABILITY, r);
        rd(`ADDR_CAPABILITY, {16'h0, r[15:8], 1'b0, r[6:0]});
        wr(`ADDR_CAPABILITY, 32'h0);
        wr(`ADDR_SETUP, 32'h0);
        wr(`ADDR_CAPABILITY, 32'hFFFF);
        rd(`ADDR_CAPABILITY, 32'h0);
        wr(`ADDR_CONTROL, r);
        rd(`ADDR_CONTROL, {25'h0, r[6:0]});
        for (int i = 0; i < 32; i++) begin
            idle();
            port_number <= i[3:0];
            port_merged <= i[4];
            m = ~(16'h1 << i[3:0]);
            if (i[4] && !i[0])
                m = m & ~(16'h2 << i[3:0]);
            wr(`ADDR_EGRESS_MASK, 32'hFFFF);
            rd(`ADDR_EGRESS_MASK, {16'h0, m});
        end
        idle();
        port_number <= 4'h3;
        port_merged <= 1'b0;
        wr(`ADDR_EGRESS_MASK, r, 4'h1);
        m = {8'hFF, r[7:0]} & 16'hFFF7;
        rd(`ADDR_EGRESS_MASK, {16'h0, m});
        for (int k = 0; k < 2; k++) begin
            wr(`ADDR_CONTROL, k ? 32'h20 : 32'h0);
            idle();
            for (int t = 0; t < 16; t++)
                look(t[3:0], k ? {7'h20, m, m[t]} : 24'h0);
            req_valid <= 1'b0;
        end
        idle();
        port_is_upstream <= 1'b1;
        wr(`ADDR_CONTROL, 32'h7F);
        rd(`ADDR_STATUS, 32'h31);
        rd(`ADDR_CONTROL, 32'h0);
        rd(`ADDR_CAPABILITY, 32'h0);
        idle();
        port_is_upstream <= 1'b0;
        rd(`ADDR_CONTROL, 32'h20);
        // Unmapped and misaligned places are refused.
        xfer(1'b0, 12'hC84, 32'h0, 4'h0, {1'b1, 32'h0});
        xfer(1'b1, 12'hC81, 32'hFFFF, 4'hF, {1'b1, 32'h0});
        idle();
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        rd(`ADDR_HEADER, 32'h0001000D);
        rd(`ADDR_CONTROL, 32'h0);
        rd(`ADDR_EGRESS_MASK, 32'h0);
        idle();
        give_verdict();
    end
endmodule : tb_peer_isolation_capability_regs
